// >>> hw/xcvr_defs.svh
// Register offsets, field positions, reset values and sizes of the transceiver
`ifndef XCVR_DEFS_SVH
`define XCVR_DEFS_SVH

// Sizes
`define XCVR_LANES        2
`define XCVR_LANE_W       8
`define XCVR_BUS_W        16
`define XCVR_LOG_W        18
`define XCVR_LOG_DEPTH    8

// Register byte offsets
`define XCVR_CTRL_OFS     12'h000
`define XCVR_STORE_OFS    12'h004
`define XCVR_STATUS_OFS   12'h008
`define XCVR_AREG_OFS     12'h00C
`define XCVR_BREG_OFS     12'h010
`define XCVR_LOG_OFS      12'h014
`define XCVR_DROPS_OFS    12'h018

// Control register fields
`define XCVR_CTRL_OVR_BIT 0
`define XCVR_CTRL_LANE0   4
`define XCVR_CTRL_LANE_W  4
`define XCVR_CTRL_RESET   32'h0000_0000

// Store register fields
`define XCVR_STORE_A_LSB  0
`define XCVR_STORE_B_LSB  2

// Status register fields
`define XCVR_STAT_MODE0   0
`define XCVR_STAT_LOGV    8
`define XCVR_STAT_LOGR    9
`define XCVR_STAT_OVF     10

// Log read word fields
`define XCVR_LOG_VALID    31

`endif

// >>> hw/xcvr_pkg.sv
// Types shared by the transceiver files
package xcvr_pkg;
   // Lane direction as seen on the status register
   typedef enum logic [1:0] {
      MODE_ISOLATE = 2'b00,
      MODE_A_TO_B  = 2'b01,
      MODE_B_TO_A  = 2'b10,
      MODE_BOTH    = 2'b11
   } lane_mode_t;

   typedef logic [7:0]  lane_byte_t;
   typedef logic [31:0] apb_word_t;
endpackage

// >>> hw/log_mem.sv
// Small storage array with registered read data
`timescale 1ns/1ps
module log_mem
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8,
   parameter int AW    = 3
)
(
   // Clock
   input  wire logic             pclk,
   // Write side
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read side
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem_reg [DEPTH];

   // Write port, no reset on the array
   always_ff @(posedge pclk)
   begin
      if (wr_en)
         mem_reg[wr_addr] <= wr_data;
   end

   // Read data comes out of a flop, old contents on collision
   always_ff @(posedge pclk)
   begin
      rd_data <= mem_reg[rd_addr];
   end

endmodule

// >>> hw/log_fifo.sv
// Capture log FIFO with valid/ready on both sides
`timescale 1ns/1ps
module log_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW-1:0] rptr_next;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic          push;
   logic          pop;
   logic          head_fresh;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   assign rptr_next  = pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
   assign count_next = CW'(count_reg + CW'(push) - CW'(pop));
   // Head written this edge is not yet readable through the read flop
   assign head_fresh = push && (count_reg == CW'(pop));

   // Pointers and fill level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wptr_reg <= AW'(wptr_reg + 1'b1);
         rptr_reg  <= rptr_next;
         count_reg <= count_next;
      end
   end

   // Flags kept in flops so both ready and valid are clean
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end
      else
      begin
         in_ready  <= (count_next != CW'(DEPTH));
         out_valid <= (count_next != '0) && !head_fresh;
      end
   end

   // Storage
   log_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem
   (
      .pclk    (pclk),
      .wr_en   (push),
      .wr_addr (wptr_reg),
      .wr_data (in_data),
      .rd_addr (rptr_next),
      .rd_data (out_data)
   );

endmodule

// >>> hw/registered_bus_transceiver.sv
// Two-lane registered bus transceiver with APB control and capture log
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "xcvr_defs.svh"
module registered_bus_transceiver
(
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire xcvr_pkg::apb_word_t    pwdata,
   output xcvr_pkg::apb_word_t         prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Per-lane control pins
   input  wire logic [1:0]             a_to_b_output_enable,
   input  wire logic [1:0]             b_to_a_output_enable_n,
   input  wire logic [1:0]             a_register_clock,
   input  wire logic [1:0]             b_register_clock,
   input  wire logic [1:0]             a_to_b_source_select,
   input  wire logic [1:0]             b_to_a_source_select,
   // Side A lines
   input  wire logic [15:0]            left_port_lines_in,
   output logic      [15:0]            left_port_lines_out,
   output logic      [15:0]            left_port_lines_oe_n,
   // Side B lines
   input  wire logic [15:0]            right_port_lines_in,
   output logic      [15:0]            right_port_lines_out,
   output logic      [15:0]            right_port_lines_oe_n,
   // Capture log back-pressure
   output logic                        log_ready
);
   import xcvr_pkg::*;

   // Lane mode seen from the effective enables
   function automatic lane_mode_t lane_mode(input logic oeab, input logic oeba_n);
      lane_mode_t m;
      m = MODE_ISOLATE;
      if (oeab && !oeba_n)
         m = MODE_BOTH;
      else if (oeab)
         m = MODE_A_TO_B;
      else if (!oeba_n)
         m = MODE_B_TO_A;
      return m;
   endfunction

   // Control state
   apb_word_t                        ctrl_reg;
   logic      [`XCVR_LANES-1:0]      a_clk_prev_reg;
   logic      [`XCVR_LANES-1:0]      b_clk_prev_reg;
   logic      [`XCVR_LANES-1:0]      sw_store_a_reg;
   logic      [`XCVR_LANES-1:0]      sw_store_b_reg;
   logic                             overflow_reg;
   logic      [15:0]                 drops_reg;

   // Storage, per lane
   lane_byte_t                       a_side_register [`XCVR_LANES];
   lane_byte_t                       b_side_register [`XCVR_LANES];

   // Effective controls and edges
   logic      [`XCVR_LANES-1:0]      eff_oeab;
   logic      [`XCVR_LANES-1:0]      eff_oeba_n;
   logic      [`XCVR_LANES-1:0]      eff_sab;
   logic      [`XCVR_LANES-1:0]      eff_sba;
   logic      [`XCVR_LANES-1:0]      a_load;
   logic      [`XCVR_LANES-1:0]      b_load;
   logic      [`XCVR_BUS_W-1:0]      a_next_word;

   // Log path
   logic                             log_in_valid;
   logic      [`XCVR_LOG_W-1:0]      log_in_data;
   logic                             log_out_valid;
   logic                             log_out_ready;
   logic      [`XCVR_LOG_W-1:0]      log_out_data;

   // Bus decode
   logic                             setup_ph;
   logic                             wr_done;
   logic                             hit_log_rd;

   assign setup_ph   = psel && !penable;
   assign wr_done    = psel && penable && pready && pwrite;
   assign hit_log_rd = setup_ph && !pwrite && (paddr == `XCVR_LOG_OFS);

   // Software override replaces the enable and select pins lane-wide
   genvar l;
   generate
      for (l = 0; l < `XCVR_LANES; l++)
      begin : g_lane
         localparam int LO = l * `XCVR_LANE_W;
         localparam int CB = `XCVR_CTRL_LANE0 + l * `XCVR_CTRL_LANE_W;
         logic ovr;
         assign ovr = ctrl_reg[`XCVR_CTRL_OVR_BIT];

         assign eff_oeab[l]   = ovr ? ctrl_reg[CB]     : a_to_b_output_enable[l];
         assign eff_oeba_n[l] = ovr ? ctrl_reg[CB + 1] : b_to_a_output_enable_n[l];
         assign eff_sab[l]    = ovr ? ctrl_reg[CB + 2] : a_to_b_source_select[l];
         assign eff_sba[l]    = ovr ? ctrl_reg[CB + 3] : b_to_a_source_select[l];

         assign a_load[l] = (a_register_clock[l] && !a_clk_prev_reg[l]) || sw_store_a_reg[l];
         assign b_load[l] = (b_register_clock[l] && !b_clk_prev_reg[l]) || sw_store_b_reg[l];

         assign a_next_word[LO +: `XCVR_LANE_W] = left_port_lines_in[LO +: `XCVR_LANE_W];

         always_ff @(posedge pclk)
         begin
            if (a_load[l])
               a_side_register[l] <= left_port_lines_in[LO +: `XCVR_LANE_W];
         end

         always_ff @(posedge pclk)
         begin
            if (b_load[l])
               b_side_register[l] <= right_port_lines_in[LO +: `XCVR_LANE_W];
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               right_port_lines_oe_n[LO +: `XCVR_LANE_W] <= 8'hFF;
               right_port_lines_out[LO +: `XCVR_LANE_W]  <= 8'h00;
            end
            else
            begin
               right_port_lines_oe_n[LO +: `XCVR_LANE_W] <= {`XCVR_LANE_W{!eff_oeab[l]}};
               // Bypass so a store shows without an extra cycle
               if (!eff_sab[l] || a_load[l])
                  right_port_lines_out[LO +: `XCVR_LANE_W] <=
                     left_port_lines_in[LO +: `XCVR_LANE_W];
               else
                  right_port_lines_out[LO +: `XCVR_LANE_W] <= a_side_register[l];
            end
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               left_port_lines_oe_n[LO +: `XCVR_LANE_W] <= 8'hFF;
               left_port_lines_out[LO +: `XCVR_LANE_W]  <= 8'h00;
            end
            else
            begin
               left_port_lines_oe_n[LO +: `XCVR_LANE_W] <= {`XCVR_LANE_W{eff_oeba_n[l]}};
               if (!eff_sba[l] || b_load[l])
                  left_port_lines_out[LO +: `XCVR_LANE_W] <=
                     right_port_lines_in[LO +: `XCVR_LANE_W];
               else
                  left_port_lines_out[LO +: `XCVR_LANE_W] <= b_side_register[l];
            end
         end
      end
   endgenerate

   // Previous clock pin levels for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_clk_prev_reg <= 2'h3;
         b_clk_prev_reg <= 2'h3;
      end
      else
      begin
         a_clk_prev_reg <= a_register_clock;
         b_clk_prev_reg <= b_register_clock;
      end
   end

   // Control register; only write side effect is storage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= `XCVR_CTRL_RESET;
      else if (wr_done && paddr == `XCVR_CTRL_OFS)
         ctrl_reg <= pwdata;
   end

   // Software store strobes last one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sw_store_a_reg <= 2'h0;
         sw_store_b_reg <= 2'h0;
      end
      else if (wr_done && paddr == `XCVR_STORE_OFS)
      begin
         sw_store_a_reg <= pwdata[`XCVR_STORE_A_LSB +: `XCVR_LANES];
         sw_store_b_reg <= pwdata[`XCVR_STORE_B_LSB +: `XCVR_LANES];
      end
      else
      begin
         sw_store_a_reg <= 2'h0;
         sw_store_b_reg <= 2'h0;
      end
   end

   // Every A store is logged with its lane mask while the log has room
   assign log_in_valid  = |a_load;
   assign log_in_data   = {a_load, a_next_word};
   assign log_out_ready = hit_log_rd;

   // Lost entries; a new loss wins over a software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         overflow_reg <= 1'b0;
         drops_reg    <= 16'h0000;
      end
      else if (log_in_valid && !log_ready)
      begin
         overflow_reg <= 1'b1;
         if (drops_reg != 16'hFFFF)
            drops_reg <= drops_reg + 16'h0001;
      end
      else if (wr_done && paddr == `XCVR_STATUS_OFS && pwdata[`XCVR_STAT_OVF])
      begin
         overflow_reg <= 1'b0;
         drops_reg    <= 16'h0000;
      end
   end

   // Log FIFO; stores are never stalled, so a full log drops and counts
   log_fifo #(.WIDTH(`XCVR_LOG_W), .DEPTH(`XCVR_LOG_DEPTH)) u_log
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (log_in_valid),
      .in_ready  (log_ready),
      .in_data   (log_in_data),
      .out_valid (log_out_valid),
      .out_ready (log_out_ready),
      .out_data  (log_out_data)
   );

   // Read data captured in setup phase, zero wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (setup_ph)
      begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (paddr == `XCVR_CTRL_OFS)
            prdata <= ctrl_reg;
         else if (paddr == `XCVR_STORE_OFS)
            prdata <= 32'h0000_0000;
         else if (paddr == `XCVR_STATUS_OFS)
         begin
            prdata[`XCVR_STAT_MODE0 +: 2]     <= lane_mode(eff_oeab[0], eff_oeba_n[0]);
            prdata[`XCVR_STAT_MODE0 + 2 +: 2] <= lane_mode(eff_oeab[1], eff_oeba_n[1]);
            prdata[4 +: `XCVR_LANES]          <= eff_sab;
            prdata[6 +: `XCVR_LANES]          <= eff_sba;
            prdata[`XCVR_STAT_LOGV]           <= log_out_valid;
            prdata[`XCVR_STAT_LOGR]           <= log_ready;
            prdata[`XCVR_STAT_OVF]            <= overflow_reg;
         end
         else if (paddr == `XCVR_AREG_OFS)
            prdata[15:0] <= {a_side_register[1], a_side_register[0]};
         else if (paddr == `XCVR_BREG_OFS)
            prdata[15:0] <= {b_side_register[1], b_side_register[0]};
         else if (paddr == `XCVR_LOG_OFS)
         begin
            // Empty log reads as zero, valid bit low
            prdata[`XCVR_LOG_VALID]         <= log_out_valid;
            prdata[`XCVR_LOG_W-1:0]         <= log_out_valid ? log_out_data : 18'h00000;
         end
         else if (paddr == `XCVR_DROPS_OFS)
            prdata[15:0] <= drops_reg;
         else
            pslverr <= 1'b1;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule

// >>> sim/far_buses_model.sv
// Far-side logic buses on sides A and B, resolving each wire with the device drive
`timescale 1ns/1ps
module far_buses_model
(
   // Clock
   input  wire logic        pclk,
   // Far-side drive
   input  wire logic [15:0] a_val,
   input  wire logic [15:0] a_en,
   input  wire logic [15:0] b_val,
   input  wire logic [15:0] b_en,
   // Device drive
   input  wire logic [15:0] a_out,
   input  wire logic [15:0] a_oe_n,
   input  wire logic [15:0] b_out,
   input  wire logic [15:0] b_oe_n,
   // Resolved wires
   output logic      [15:0] a_line,
   output logic      [15:0] b_line
);
   logic [15:0] a_last_reg;
   logic [15:0] b_last_reg;

   // Clash of unequal levels gives unknown; no pull, so a floating bit inverts its last level
   function automatic logic res(input logic d, input logic dn, input logic v, input logic e,
                                input logic l);
      if (!dn && e)
         return (d === v) ? v : 1'bx;
      if (!dn)
         return d;
      if (e)
         return v;
      return ~l;
   endfunction

   // Wire levels
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         a_line[i] = res(a_out[i], a_oe_n[i], a_val[i], a_en[i], a_last_reg[i]);
         b_line[i] = res(b_out[i], b_oe_n[i], b_val[i], b_en[i], b_last_reg[i]);
      end
   end

   // Last level, so a stale value never reads as valid
   always_ff @(posedge pclk)
   begin
      a_last_reg <= a_line;
      b_last_reg <= b_line;
   end
endmodule

// >>> sim/xcvr_chk.sv
// Port checker for the registered bus transceiver
`timescale 1ns/1ps
module xcvr_chk
(
   // Clock, reset and APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        log_ready,
   // Lane controls
   input wire logic [1:0]  a_to_b_output_enable,
   input wire logic [1:0]  b_to_a_output_enable_n,
   input wire logic [1:0]  a_register_clock,
   input wire logic [1:0]  a_to_b_source_select,
   input wire logic [1:0]  b_to_a_source_select,
   // Lines
   input wire logic [15:0] left_port_lines_in,
   input wire logic [15:0] left_port_lines_out,
   input wire logic [15:0] left_port_lines_oe_n,
   input wire logic [15:0] right_port_lines_in,
   input wire logic [15:0] right_port_lines_out,
   input wire logic [15:0] right_port_lines_oe_n
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Lane 0 shorthands
   wire logic        oab   = a_to_b_output_enable[0];
   wire logic        oba_n = b_to_a_output_enable_n[0];
   wire logic        st_ab = oab && oba_n && a_to_b_source_select[0];
   wire logic        setup = psel && !penable;
   wire logic [7:0]  la    = left_port_lines_in[7:0];
   wire logic [7:0]  rb    = right_port_lines_in[7:0];
   wire logic [15:0] l_oe  = left_port_lines_oe_n;
   wire logic [15:0] r_oe  = right_port_lines_oe_n;

   a_iso_float: assert property (
      !oab && oba_n |=> l_oe[7:0] == 8'hFF && r_oe[7:0] == 8'hFF)
      else $error("Lane 0 drives while isolated");
   a_lane_split: assert property (
      !a_to_b_output_enable[1] && b_to_a_output_enable_n[1]
      |=> {l_oe[15:8], r_oe[15:8]} == 16'hFFFF)
      else $error("Lane 1 drives while isolated");
   a_ab_live: assert property (
      oab && oba_n && !a_to_b_source_select[0]
      |=> right_port_lines_out[7:0] == $past(la) && r_oe[7:0] == 8'h00)
      else $error("Side B does not follow side A");
   a_ba_live: assert property (
      !oab && !oba_n && !b_to_a_source_select[0]
      |=> left_port_lines_out[7:0] == $past(rb) && l_oe[7:0] == 8'h00)
      else $error("Side A does not follow side B");
   // Stored drive must ignore side A while no store can happen
   a_stored_quiet: assert property (
      (st_ab && !psel && $stable(a_register_clock[0]))[*4] |-> $stable(right_port_lines_out[7:0]))
      else $error("Stored side B moved without a store");
   a_store_bypass: assert property (
      st_ab && $rose(a_register_clock[0]) |=> right_port_lines_out[7:0] == $past(la))
      else $error("New stored value not shown on side B");
   a_cross_drive: assert property (
      oab && !oba_n && a_to_b_source_select[0] && b_to_a_source_select[0]
      |=> l_oe[7:0] == 8'h00 && r_oe[7:0] == 8'h00)
      else $error("Both sides not driven");
   a_ready_once: assert property (setup |=> pready ##1 !pready)
      else $error("Ready is not a one cycle answer");
   a_ready_cause: assert property (pready |-> $past(setup))
      else $error("Ready without setup");
   a_err_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h018))
      else $error("Error response wrong for address");

   // Main scenarios
   c_store: cover property (st_ab && $rose(a_register_clock[0]));
   c_err: cover property (pready && pslverr);
   c_full: cover property (!log_ready);
endmodule

bind registered_bus_transceiver xcvr_chk xcvr_chk_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .log_ready(log_ready),
   .a_to_b_output_enable(a_to_b_output_enable), .b_to_a_output_enable_n(b_to_a_output_enable_n),
   .a_register_clock(a_register_clock), .a_to_b_source_select(a_to_b_source_select),
   .b_to_a_source_select(b_to_a_source_select), .left_port_lines_in(left_port_lines_in),
   .left_port_lines_out(left_port_lines_out), .left_port_lines_oe_n(left_port_lines_oe_n),
   .right_port_lines_in(right_port_lines_in), .right_port_lines_out(right_port_lines_out),
   .right_port_lines_oe_n(right_port_lines_oe_n)
);

// >>> sim/tb.sv
// Self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
module tb;
   import xcvr_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, log_ready;
   logic [11:0] paddr;
   apb_word_t   pwdata, prdata, rd;
   logic [1:0]  oab, oba_n, ack, bck, sab, sba;
   logic [15:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, a_val, b_val, a_en, b_en;
   int          errors, compares, i;

   // Device and far-side buses
   registered_bus_transceiver registered_bus_transceiver_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .a_to_b_output_enable(oab), .b_to_a_output_enable_n(oba_n), .a_register_clock(ack),
      .b_register_clock(bck), .a_to_b_source_select(sab), .b_to_a_source_select(sba),
      .left_port_lines_in(a_in), .left_port_lines_out(a_out), .left_port_lines_oe_n(a_oe_n),
      .right_port_lines_in(b_in), .right_port_lines_out(b_out), .right_port_lines_oe_n(b_oe_n),
      .log_ready(log_ready)
   );
   far_buses_model far_buses_model_i
   (
      .pclk(pclk), .a_val(a_val), .a_en(a_en), .b_val(b_val), .b_en(b_en), .a_out(a_out),
      .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n), .a_line(a_in), .b_line(b_in)
   );

   // 10 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic stop_test();
      $display("Mismatches %0d of %0d comparisons", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; waits for ready under a bound
   task automatic apb(input logic wr, input logic [11:0] ad, input apb_word_t wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Ready never came: count it and close the run
      if (n >= 20)
      begin
         errors++;
         stop_test();
      end
   endtask

   // Lane 0 mode change through isolation, so no two drivers ever meet
   task automatic mode(input logic e_ab, input logic e_ba_n, input logic s_ab, input logic s_ba);
      @(posedge pclk);
      oab[0] <= 1'b0;
      oba_n[0] <= 1'b1;
      tick(2);
      oab[0] <= e_ab;
      oba_n[0] <= e_ba_n;
      sab[0] <= s_ab;
      sba[0] <= s_ba;
      a_en[7:0] <= {8{e_ba_n}};
      b_en[7:0] <= {8{!e_ab}};
      tick(2);
   endtask

   task automatic pulse(input logic [1:0] a, input logic [1:0] b);
      @(posedge pclk);
      ack <= a;
      bck <= b;
      tick(1);
      ack <= 2'b00;
      bck <= 2'b00;
      tick(1);
   endtask

   task automatic drive(input logic [15:0] a, input logic [15:0] b);
      @(posedge pclk);
      a_val <= a;
      b_val <= b;
      tick(2);
   endtask

   task automatic lane_a(input logic [15:0] e);
      chk({16'h0000, a_oe_n[7:0], a_out[7:0]}, {16'h0000, e});
   endtask

   task automatic lane_b(input logic [15:0] e);
      chk({16'h0000, b_oe_n[7:0], b_out[7:0]}, {16'h0000, e});
   endtask

   // Main sequence
   initial
   begin
      errors = 0;
      compares = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {oab, ack, bck, sab, sba} = '0;
      oba_n = 2'b11;
      a_val = 16'h965A;
      b_val = 16'h3CC3;
      a_en = 16'hFFFF;
      b_en = 16'hFFFF;
      tick(2);
      presetn <= 1'b1;
      tick(1);
      chk({a_oe_n, b_oe_n}, 32'hFFFF_FFFF); // both sides float
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0200);
      pulse(2'b01, 2'b01);
      pulse(2'b10, 2'b00);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(rd, 32'h0000_965A); // per-lane store in isolation
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(rd & 32'h0000_00FF, 32'h0000_00C3); // B store in isolation
      chk({a_oe_n, b_oe_n}, 32'hFFFF_FFFF); // outputs stay off
      drive(16'h965A, 16'h3C77);
      apb(1'b1, 12'h004, 32'h0000_0004);
      tick(2);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(rd & 32'h0000_00FF, 32'h0000_0077);
      mode(1'b1, 1'b1, 1'b0, 1'b0);
      drive(16'h9644, 16'h3C77);
      lane_b(16'h0044); // side B follows side A
      pulse(2'b01, 2'b00);
      drive(16'h9611, 16'h3C77);
      lane_b(16'h0011); // still follows after a store
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(rd, 32'h0000_9644); // store during live copy
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0301);
      mode(1'b1, 1'b1, 1'b1, 1'b0);
      drive(16'h9699, 16'h3C77);
      lane_b(16'h0044); // side A ignored
      pulse(2'b01, 2'b00);
      lane_b(16'h0099); // new value shown
      mode(1'b0, 1'b0, 1'b0, 1'b0);
      drive(16'h9699, 16'h3C21);
      lane_a(16'h0021); // side A follows side B
      mode(1'b0, 1'b0, 1'b0, 1'b1);
      lane_a(16'h0077); // side A from B register
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0342); // B-to-A mode and stored select seen
      pulse(2'b00, 2'b01);
      lane_a(16'h0021); // B store shown
      mode(1'b1, 1'b0, 1'b1, 1'b1);
      lane_a(16'h0021); // side A from B register
      lane_b(16'h0099); // side B from A register
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0353); // both directions enabled
      pulse(2'b01, 2'b00);
      lane_b(16'h0021); // clock ungated while driving
      mode(1'b1, 1'b0, 1'b0, 1'b0);
      chk({16'h0000, a_oe_n[7:0], b_oe_n[7:0]}, 32'h0000_0000); // both sides driven live
      // Capture log: empty it, overfill by one, drain
      mode(1'b0, 1'b1, 1'b0, 1'b0);
      rd = 32'h8000_0000;
      for (i = 0; i < 16 && rd[31]; i++)
         apb(1'b0, 12'h014, 32'h0000_0000);
      for (i = 1; i <= 9; i++)
      begin
         drive({8'h96, i[7:0]}, 16'h3C21);
         pulse(2'b01, 2'b00);
      end
      chk({31'h0, log_ready}, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0500);
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      for (i = 1; i <= 8; i++)
      begin
         apb(1'b0, 12'h014, 32'h0000_0000);
         chk(rd, {16'h8001, 8'h96, i[7:0]}); // stored words in order
      end
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0400);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0200);
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // Override keeps both lanes isolated but sets lane 0 selects
      apb(1'b1, 12'h000, 32'h0000_02E1);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_02E1); // override word kept
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0250); // selects taken from override
      chk({a_oe_n, b_oe_n}, 32'hFFFF_FFFF); // override isolation floats
      stop_test();
   end
endmodule
